// [core/lae_map.svh]
// Status word layout, reset values and default range for the alarm block
`ifndef LAE_MAP_SVH
`define LAE_MAP_SVH
`define LAE_CHANNELS      4        // Alarms per loop
`define LAE_BITS_PER_CH   3        // Active, unacked, enabled per alarm
`define LAE_ACT_OFS       0        // Active bit within a channel group
`define LAE_UNACK_OFS     1        // Unacknowledged bit within a group
`define LAE_EN_OFS        2        // Enabled bit within a group
`define LAE_OS_BIT        12       // Service exempt flag
`define LAE_CC_BIT        13       // Setup changed flag
`define LAE_NA_BIT        14       // Loop unacknowledged flag
`define LAE_AE_BIT        15       // Loop event active flag
`define LAE_STATUS_RST    16'h0000 // Status word after reset
`define LAE_DFLT_RANGE_LO 0        // Default low range, 0.0
`define LAE_DFLT_RANGE_HI 100      // Default high range, 100.0
`define LAE_PRIO_ACK_MIN  3'h1     // Lowest priority code needing ack
`define LAE_PRIO_ACK_MAX  3'h4     // Highest priority code needing ack
`endif

// [core/lae_pkg.sv]
// Types shared by the loop alarm evaluator
package lae_pkg;
  // Alarm channel comparison kind
  typedef enum logic [2:0] {
    LAE_NONE,
    LAE_UPPER_THRESHOLD,
    LAE_UNDER_THRESHOLD,
    LAE_POSITIVE_GAP,
    LAE_NEGATIVE_GAP,
    LAE_SETPOINT_GAP,
    LAE_SPAN_EXIT
  } lae_alarm_e;
  // Alarm priority code, 1 highest, 5 display only
  typedef logic [2:0] lae_prio_t;
endpackage : lae_pkg

// [core/lae_compare.sv]
// Trip and clear conditions of one alarm channel
`timescale 1ns/100ps
module lae_compare #(
  parameter int DATA_W = 16
) (
  input  lae_pkg::lae_alarm_e           kind_in,   // Comparison kind
  input  wire logic signed [DATA_W-1:0] proc_in,   // Process input
  input  wire logic signed [DATA_W-1:0] dev_in,    // Deviation input
  input  wire logic signed [DATA_W-1:0] limit_in,  // Alarm limit
  input  wire logic signed [DATA_W-1:0] dband_in,  // Deadband
  input  wire logic signed [DATA_W-1:0] rng_lo_in, // Range low limit
  input  wire logic signed [DATA_W-1:0] rng_hi_in, // Range high limit
  output logic                          trip_out,  // Trip condition
  output logic                          clear_out  // Clear condition
);
  import lae_pkg::*;
  localparam int XW = DATA_W + 2;  // Headroom for sums and differences

  // Sign extension to the working width
  function automatic logic signed [XW-1:0] ext(
    input logic signed [DATA_W-1:0] v);
    return XW'(v);
  endfunction : ext

  logic signed [XW-1:0] gap;   // Process minus deviation
  logic signed [XW-1:0] mag;   // Absolute gap
  logic signed [XW-1:0] lim;   // Limit, extended
  logic signed [XW-1:0] db;    // Deadband, extended

  // Compare per kind; never trips when unconfigured
  always_comb begin
    gap       = ext(proc_in) - ext(dev_in);
    mag       = gap[XW-1] ? -gap : gap;
    lim       = ext(limit_in);
    db        = ext(dband_in);
    trip_out  = 1'b0;
    clear_out = 1'b1;
    case (kind_in)
      LAE_UPPER_THRESHOLD: begin
        trip_out  = ext(proc_in) >= lim;
        clear_out = ext(proc_in) < (lim - db);
      end
      LAE_UNDER_THRESHOLD: begin
        trip_out  = ext(proc_in) <= lim;
        clear_out = ext(proc_in) > (lim + db);
      end
      LAE_POSITIVE_GAP: begin
        trip_out  = gap >= lim;
        clear_out = gap < (lim - db);
      end
      LAE_NEGATIVE_GAP: begin
        trip_out  = -gap >= lim;
        clear_out = -gap < (lim - db);
      end
      LAE_SETPOINT_GAP: begin
        trip_out  = mag >= lim;
        clear_out = mag < (lim - db);
      end
      LAE_SPAN_EXIT: begin
        trip_out  = (ext(proc_in) >= ext(rng_hi_in)) ||
                    (ext(proc_in) <= ext(rng_lo_in));
        // Back inside the span by the deadband on both edges
        clear_out = (ext(proc_in) < (ext(rng_hi_in) - db)) &&
                    (ext(proc_in) > (ext(rng_lo_in) + db));
      end
      default: begin
        trip_out  = 1'b0;
        clear_out = 1'b1;
      end
    endcase
  end
endmodule : lae_compare

// [core/lae_qualify.sv]
// Delay-in and delay-out qualification of one alarm channel
`timescale 1ns/100ps
module lae_qualify #(
  parameter int CNT_W = 8
) (
  input  wire logic             clk_in,     // Clock
  input  wire logic             rst_n_in,   // Sync reset, active low
  input  wire logic             strobe_in,  // Scan cycle strobe
  input  wire logic             enable_in,  // Channel enabled
  input  wire logic             force_in,   // Cold start clear
  input  wire logic             trip_in,    // Trip condition
  input  wire logic             clear_in,   // Clear condition
  input  wire logic [CNT_W-1:0] dly_in_in,  // Delay-in, in scans
  input  wire logic [CNT_W-1:0] dly_out_in, // Delay-out, in scans
  output logic                  active_out  // Qualified alarm state
);
  logic [CNT_W-1:0] cnt_q;   // Scans the pending condition has held

  // Count held scans, flip state once the delay is met
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || force_in || !enable_in) begin
      active_out <= 1'b0;
      cnt_q      <= '0;
    end else if (strobe_in) begin
      if (!active_out) begin
        if (!trip_in) begin
          cnt_q <= '0;        // Broken run restarts delay-in
        end else if (cnt_q >= dly_in_in) begin
          active_out <= 1'b1;
          cnt_q      <= '0;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end else begin
        if (!clear_in) begin
          cnt_q <= '0;        // Broken run restarts delay-out
        end else if (cnt_q >= dly_out_in) begin
          active_out <= 1'b0;
          cnt_q      <= '0;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end
endmodule : lae_qualify

// [core/lae_loop_alarm_evaluator.sv]
// Four-channel loop alarm evaluator with packed alarm status word
//
// How it works
// - Upper threshold trips at limit, deadband clear
// - Under threshold trips at limit, deadband clear
// - Positive gap: process minus deviation
// - Negative gap: deviation minus process
// - Setpoint gap uses absolute difference
// - Span exit trips at range edges
// - Span exit clears inside range by deadband
// - Warm start keeps alarm and ack state
// - Cold start zeroes alarm_out and resets alarms
// - Cold start loads enables from settings
// - Three status bits per alarm, bits 0-11
// - Active and unacknowledged bits reflect alarm
// - Disabled channel clears bits, keeps settings
// - Bit 12 service exempt, remote only
// - Bit 13 setup changed, remote clears
// - Bit 15 any loop event active
// - Bit 14 unacked; writing zero acknowledges all
// - Trip only after delay-in held
// - Clear only after delay-out held
// - Ringback re-requests ack on clear
// - Default range 0.0 to 100.0
`timescale 1ns/100ps
`include "lae_map.svh"
module lae_loop_alarm_evaluator #(
  parameter int DATA_W = 16,  // Width of engineering values
  parameter int CNT_W  = 8    // Width of delay counts, in scans
) (
  input  wire logic                   clk_in,          // Clock, 50 MHz
  input  wire logic                   rst_n_in,        // Sync reset
  input  wire logic                   scan_strobe_in,  // Scan cycle tick
  input  wire logic                   start_pulse_in,  // Power-up start
  input  wire logic                   start_cold_in,   // Start is cold
  input  wire logic signed [DATA_W-1:0] process_in,    // Process input
  input  wire logic signed [DATA_W-1:0] deviation_in,  // Deviation input
  input  wire logic                   range_valid_in,  // Range configured
  input  wire logic signed [DATA_W-1:0] range_lo_in,   // Range low
  input  wire logic signed [DATA_W-1:0] range_hi_in,   // Range high
  input  lae_pkg::lae_alarm_e         kind_in [`LAE_CHANNELS], // Types
  input  wire logic [`LAE_CHANNELS-1:0][DATA_W-1:0] limit_in,  // Limits
  input  wire logic [`LAE_CHANNELS-1:0][DATA_W-1:0] dband_in,  // Deadbands
  input  wire logic [`LAE_CHANNELS-1:0][CNT_W-1:0] dly_in_in,  // Delay-in
  input  wire logic [`LAE_CHANNELS-1:0][CNT_W-1:0] dly_out_in, // Delay-out
  input  lae_pkg::lae_prio_t          prio_in [`LAE_CHANNELS], // Priority
  input  wire logic [`LAE_CHANNELS-1:0] ringback_in,     // Ringback on
  input  wire logic [`LAE_CHANNELS-1:0] coldstart_enable_setting_in, // En
  input  wire logic [`LAE_CHANNELS-1:0] enable_set_in,   // Enable pulse
  input  wire logic [`LAE_CHANNELS-1:0] enable_clr_in,   // Disable pulse
  input  wire logic [`LAE_CHANNELS-1:0] ack_in,          // Local ack pulse
  input  wire logic                   cfg_changed_in,  // Setup changed
  input  wire logic                   status_wr_in,    // Remote write
  input  wire logic [15:0]            status_wdata_in, // Remote data
  output logic [15:0]                 status_out,      // Status word
  output logic [`LAE_CHANNELS-1:0]    alarm_out        // Alarm states
);
  import lae_pkg::*;
  localparam int NCH = `LAE_CHANNELS;  // Channel count

  // Refuse widths the arithmetic cannot serve
  if (DATA_W < 4 || DATA_W > 30) begin : g_bad_width
    $error("DATA_W must lie between 4 and 30");
  end
  if (CNT_W < 1 || CNT_W > 16) begin : g_bad_cnt
    $error("CNT_W must lie between 1 and 16");
  end

  // Priorities 1 to 4 need acknowledgment, 5 only displays
  function automatic logic needs_ack(input lae_prio_t p);
    return (p >= `LAE_PRIO_ACK_MIN) && (p <= `LAE_PRIO_ACK_MAX);
  endfunction : needs_ack

  logic                   cold_w;       // Cold start this cycle
  logic signed [DATA_W-1:0] rng_lo_w;   // Effective range low
  logic signed [DATA_W-1:0] rng_hi_w;   // Effective range high
  logic [NCH-1:0]         trip_w;       // Raw trip conditions
  logic [NCH-1:0]         clear_w;      // Raw clear conditions
  logic [NCH-1:0]         qual_w;       // Qualified states
  logic [NCH-1:0]         act_w;        // Active, gated by enable
  logic [NCH-1:0]         rise_w;       // Alarm just tripped
  logic [NCH-1:0]         fall_w;       // Alarm just cleared
  logic [NCH-1:0]         need_ack_w;   // Priority needs ack
  logic [NCH-1:0]         ack_all_w;    // Acknowledge strobes
  logic                   na_wr0_w;     // Remote wrote NA as zero
  logic [NCH-1:0]         en_q;         // Channel enables
  logic [NCH-1:0]         act_prev_q;   // Active one cycle ago
  logic [NCH-1:0]         unack_q;      // Awaiting acknowledgment
  logic [NCH-1:0]         unack_d;      // Next unack state
  logic [NCH-1:0]         unack_w;      // Unacked, gated by enable
  logic                   os_q;         // Service exempt flag
  logic                   cc_q;         // Setup changed flag
  logic [15:0]            status_q;     // Registered status word
  logic [15:0]            status_d;     // Packed status word

  // Cold start recognised on the start pulse
  assign cold_w = start_pulse_in && start_cold_in;

  // Unconfigured range falls back to the default span
  assign rng_lo_w = range_valid_in ? range_lo_in
                                   : DATA_W'(`LAE_DFLT_RANGE_LO);
  assign rng_hi_w = range_valid_in ? range_hi_in
                                   : DATA_W'(`LAE_DFLT_RANGE_HI);

  // One comparator and one qualifier per channel
  for (genvar g = 0; g < NCH; g++) begin : g_chan
    lae_compare #(
      .DATA_W (DATA_W)
    ) u_cmp (
      .kind_in   (kind_in[g]),
      .proc_in   (process_in),
      .dev_in    (deviation_in),
      .limit_in  (limit_in[g]),
      .dband_in  (dband_in[g]),
      .rng_lo_in (rng_lo_w),
      .rng_hi_in (rng_hi_w),
      .trip_out  (trip_w[g]),
      .clear_out (clear_w[g])
    );
    lae_qualify #(
      .CNT_W (CNT_W)
    ) u_qual (
      .clk_in     (clk_in),
      .rst_n_in   (rst_n_in),
      .strobe_in  (scan_strobe_in),
      .enable_in  (en_q[g]),
      .force_in   (cold_w),
      .trip_in    (trip_w[g]),
      .clear_in   (clear_w[g]),
      .dly_in_in  (dly_in_in[g]),
      .dly_out_in (dly_out_in[g]),
      .active_out (qual_w[g])
    );
    assign need_ack_w[g] = needs_ack(prio_in[g]);
  end

  // Disabled channels never show active
  assign act_w     = qual_w & en_q;
  assign unack_w   = unack_q & en_q;
  assign alarm_out = act_w;
  assign rise_w    = act_w & ~act_prev_q;
  assign fall_w    = ~act_w & act_prev_q & en_q;
  assign na_wr0_w  = status_wr_in && !status_wdata_in[`LAE_NA_BIT];
  assign ack_all_w = ack_in | {NCH{na_wr0_w}};

  // Channel enables: cold start loads settings, warm start keeps
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      en_q <= '0;
    end else if (cold_w) begin
      en_q <= coldstart_enable_setting_in;
    end else begin
      // Disable wins over a same-cycle enable
      en_q <= (en_q | enable_set_in) & ~enable_clr_in;
    end
  end

  // Previous active state for edge detection
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || cold_w) begin
      act_prev_q <= '0;
    end else begin
      act_prev_q <= act_w;
    end
  end

  // Acknowledgment tracking; a new request beats a same-cycle ack
  always_comb begin
    unack_d = (unack_q & ~ack_all_w)
            | (rise_w & need_ack_w)
            | (fall_w & ringback_in & need_ack_w & ~unack_q);
    unack_d = unack_d & en_q;
  end

  // Unacked state; warm start leaves it untouched
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || cold_w) begin
      unack_q <= '0;
    end else begin
      unack_q <= unack_d;
    end
  end

  // Service exempt flag, written only by the remote station
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      os_q <= 1'b0;
    end else if (status_wr_in) begin
      os_q <= status_wdata_in[`LAE_OS_BIT];
    end
  end

  // Setup changed flag; a new change beats a remote clear
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cc_q <= 1'b0;
    end else if (cfg_changed_in) begin
      cc_q <= 1'b1;
    end else if (status_wr_in && !status_wdata_in[`LAE_CC_BIT]) begin
      cc_q <= 1'b0;
    end
  end

  // Pack the status word from live state
  always_comb begin
    status_d = `LAE_STATUS_RST;
    for (int i = 0; i < NCH; i++) begin
      status_d[i*`LAE_BITS_PER_CH + `LAE_ACT_OFS]   = act_w[i];
      status_d[i*`LAE_BITS_PER_CH + `LAE_UNACK_OFS] = unack_w[i];
      status_d[i*`LAE_BITS_PER_CH + `LAE_EN_OFS]    = en_q[i];
    end
    status_d[`LAE_OS_BIT] = os_q;
    status_d[`LAE_CC_BIT] = cc_q;
    status_d[`LAE_NA_BIT] = |unack_w;
    status_d[`LAE_AE_BIT] = |act_w;
  end

  // Status word register seen by the remote station
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      status_q <= `LAE_STATUS_RST;
    end else begin
      status_q <= status_d;
    end
  end
  assign status_out = status_q;

  // Checks on the behaviour above
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  // Quiet cycle: no strobe, no start, no enable change
  sequence s_quiet;
    !scan_strobe_in && !start_pulse_in &&
    (enable_set_in == '0) && (enable_clr_in == '0);
  endsequence

  // Channel 0 trips with no delay on a strobe
  sequence s_trip0;
    scan_strobe_in && en_q[0] && !qual_w[0] && trip_w[0] &&
    (dly_in_in[0] == '0) && !start_pulse_in && !enable_clr_in[0];
  endsequence

  // Channel 0 newly active with priority needing ack
  sequence s_rise0;
    rise_w[0] && need_ack_w[0] && !enable_clr_in[0] && !start_pulse_in;
  endsequence

  // Warm start with nothing else going on
  sequence s_warm;
    start_pulse_in && !start_cold_in && !scan_strobe_in &&
    (enable_set_in == '0) && (enable_clr_in == '0);
  endsequence

  a_cold_clear: assert property (
    cold_w |=> (act_w == '0) && (unack_q == '0))
    else $error("cold start left an alarm set");

  a_cold_enables: assert property (
    cold_w |=> (en_q == $past(coldstart_enable_setting_in)))
    else $error("cold start did not load enables");

  a_warm_keeps: assert property (
    s_warm |=> $stable(act_w) && $stable(en_q))
    else $error("warm start disturbed alarm state");

  a_hold_between: assert property (
    s_quiet |=> $stable(act_w))
    else $error("alarm changed without scan strobe");

  a_trip_nodelay: assert property (
    s_trip0 |=> act_w[0] ##1 status_out[`LAE_ACT_OFS])
    else $error("channel 0 failed to trip on strobe");

  a_unack_rise: assert property (
    s_rise0 |=> unack_q[0] ##1 status_out[`LAE_UNACK_OFS])
    else $error("new alarm not marked unacknowledged");

  a_disable_clear: assert property (
    !en_q[3] |=> (status_out[3*`LAE_BITS_PER_CH +: `LAE_BITS_PER_CH] == '0))
    else $error("disabled channel shows status bits");

  a_event_flag: assert property (
    ##1 (status_out[`LAE_AE_BIT] == $past(|act_w)))
    else $error("loop event flag wrong");

  a_cc_sets: assert property (
    cfg_changed_in |=> cc_q ##1 status_out[`LAE_CC_BIT])
    else $error("setup changed flag not set");

  a_os_write: assert property (
    status_wr_in |=> (os_q == $past(status_wdata_in[`LAE_OS_BIT])))
    else $error("service exempt flag ignored write");

  a_na_ack_all: assert property (
    (na_wr0_w && (rise_w == '0) && (fall_w == '0)) |=> (unack_q == '0)
      ##1 !status_out[`LAE_NA_BIT])
    else $error("acknowledge all left events unacked");

  // Channel 0 clears after acknowledgment with ringback on
  sequence s_fall0;
    fall_w[0] && ringback_in[0] && need_ack_w[0] && !unack_q[0] &&
    !start_pulse_in && !enable_clr_in[0];
  endsequence

  a_ringback: assert property (
    s_fall0 |=> unack_q[0])
    else $error("ringback did not request ack");

  a_ack_clears: assert property (
    (ack_in[0] && !rise_w[0] && !fall_w[0]) |=> !unack_q[0])
    else $error("local acknowledge ignored");

  a_clear_nodelay: assert property (
    (scan_strobe_in && qual_w[0] && clear_w[0] && (dly_out_in[0] == '0))
      |=> !act_w[0])
    else $error("channel 0 failed to clear on strobe");

  a_no_trip: assert property (
    (!qual_w[0] && !(scan_strobe_in && trip_w[0])) |=> !qual_w[0])
    else $error("channel 0 tripped without condition");

  a_enable_bits: assert property (
    ##1 ({status_out[11], status_out[8], status_out[5], status_out[2]}
      == $past(en_q)))
    else $error("enabled bits misplaced");

  a_active_bits: assert property (
    ##1 ({status_out[9], status_out[6], status_out[3], status_out[0]}
      == $past(act_w)))
    else $error("active bits misplaced");

  a_upper_trip: assert property (
    ((kind_in[0] == LAE_UPPER_THRESHOLD) &&
     (process_in >= $signed(limit_in[0]))) |-> trip_w[0])
    else $error("upper threshold missed trip");

  a_under_trip: assert property (
    ((kind_in[1] == LAE_UNDER_THRESHOLD) &&
     (process_in <= $signed(limit_in[1]))) |-> trip_w[1])
    else $error("under threshold missed trip");

  a_span_trip: assert property (
    ((kind_in[3] == LAE_SPAN_EXIT) &&
     ((process_in >= rng_hi_w) || (process_in <= rng_lo_w)))
      |-> trip_w[3])
    else $error("span exit missed trip");

  a_cc_clear: assert property (
    (status_wr_in && !status_wdata_in[`LAE_CC_BIT] && !cfg_changed_in)
      |=> !cc_q)
    else $error("setup changed flag ignored clear");
endmodule : lae_loop_alarm_evaluator

// [verif/lae_station_model.sv]
// Remote supervisory station that writes and reads the status word
`timescale 1ns/100ps
module lae_station_model (
  input  wire logic        clk_in,    // Clock
  input  wire logic [15:0] status_in, // Status word from the block
  output logic             wr_out,    // Remote write strobe
  output logic [15:0]      wdata_out  // Remote write data
);
  // Idle bus at time zero
  initial begin
    wr_out    = 1'b0;
    wdata_out = 16'h0000;
  end
  // One write cycle; data scrambled once the strobe drops
  task automatic write_word(input logic [15:0] data);
    @(negedge clk_in);
    wr_out    = 1'b1;
    wdata_out = data;
    @(negedge clk_in);
    wr_out    = 1'b0;
    wdata_out = ~data;
  endtask : write_word
  // Sample the status word where it is settled
  task automatic read_word(output logic [15:0] data);
    @(negedge clk_in);
    data = status_in;
  endtask : read_word
endmodule : lae_station_model

// [verif/lae_loop_alarm_evaluator_tb_top.sv]
// Self-checking bench for the loop alarm evaluator
`timescale 1ns/100ps
`include "lae_map.svh"
`define LAE_CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
  err_total++; $display("Error t=%0t got %h exp %h", $time, got, exp); end end
module lae_loop_alarm_evaluator_tb_top;
  import lae_pkg::*;
  localparam int DW = 16;                      // Value width
  logic                 clk_in = 1'b0;         // Clock
  logic                 rst_n;                 // Reset, active low
  logic                 strobe, start_p;       // Scan tick, start pulse
  logic                 start_c, rng_v;        // Cold select, range valid
  logic signed [DW-1:0] proc, deviation;       // Process, deviation
  logic signed [DW-1:0] rng_low, rng_high;     // Range limits
  lae_alarm_e           kind [`LAE_CHANNELS];  // Channel kinds
  lae_prio_t            prio [`LAE_CHANNELS];  // Priorities
  logic [3:0][DW-1:0]   limit, dband;          // Limits, deadbands
  logic [3:0][7:0]      dly_i, dly_o;          // Delays in scans
  logic [3:0]           ringback, cold_enab;   // Ringback, cold enables
  logic [3:0]           enab_set, enab_clr;    // Enable pulses
  logic [3:0]           ack, alarm;            // Local ack, alarm states
  logic                 cfg_ch, wr;            // Setup change, write
  logic [15:0]          wdata, status;         // Write data, status
  logic [3:0]           act_m, un_m, enab_m;   // Expected channel state
  logic                 exempt_m, changed_m;   // Expected loop flags
  int                   err_total, comparisons; // Tallies
  localparam logic [3:0] NEEDACK = 4'b1101;    // Priority 5 on channel 1
  // Free running 50 MHz clock
  always #10 clk_in = ~clk_in;
  // Remote station
  lae_station_model st (.clk_in(clk_in), .status_in(status), .wr_out(wr),
    .wdata_out(wdata));
  // Block under test
  lae_loop_alarm_evaluator dut (.clk_in(clk_in), .rst_n_in(rst_n),
    .scan_strobe_in(strobe), .start_pulse_in(start_p),
    .start_cold_in(start_c), .process_in(proc), .deviation_in(deviation),
    .range_valid_in(rng_v), .range_lo_in(rng_low), .range_hi_in(rng_high),
    .kind_in(kind), .limit_in(limit), .dband_in(dband), .dly_in_in(dly_i),
    .dly_out_in(dly_o), .prio_in(prio), .ringback_in(ringback),
    .coldstart_enable_setting_in(cold_enab), .enable_set_in(enab_set),
    .enable_clr_in(enab_clr), .ack_in(ack), .cfg_changed_in(cfg_ch),
    .status_wr_in(wr), .status_wdata_in(wdata), .status_out(status),
    .alarm_out(alarm));
  // Expected status word from the model state
  function automatic logic [15:0] pack();
    logic [15:0] w;
    w = 16'h0000;
    for (int i = 0; i < 4; i++) begin
      w[3*i+`LAE_ACT_OFS]   = act_m[i];
      w[3*i+`LAE_UNACK_OFS] = un_m[i];
      w[3*i+`LAE_EN_OFS]    = enab_m[i];
    end
    w[`LAE_OS_BIT] = exempt_m;
    w[`LAE_CC_BIT] = changed_m;
    w[`LAE_NA_BIT] = |un_m;
    w[`LAE_AE_BIT] = |act_m;
    return w;
  endfunction : pack
  // Read status through the station and compare
  task automatic check_status();
    logic [15:0] w;
    st.read_word(w);
    `LAE_CHK(w, pack())
  endtask : check_status
  // One channel setting
  task automatic cfg(input int ch, input lae_alarm_e k, input int lim,
                     input int db);
    kind[ch]  = k;
    limit[ch] = DW'(lim);
    dband[ch] = DW'(db);
  endtask : cfg
  // One scan with given inputs and the alarms expected after it
  task automatic scan(input int p, input int d, input logic [3:0] exp);
    logic [3:0] rise, fall;
    @(negedge clk_in);
    proc      = DW'(p);
    deviation = DW'(d);
    strobe    = 1'b1;
    @(negedge clk_in);
    strobe = 1'b0;
    @(negedge clk_in);
    `LAE_CHK(alarm, exp)
    rise  = exp & ~act_m;
    fall  = act_m & ~exp;
    un_m  = (un_m | rise | (fall & ringback & ~un_m)) & NEEDACK & enab_m;
    act_m = exp;
    @(negedge clk_in);
    check_status();
  endtask : scan
  // Power-up start, cold or warm
  task automatic start(input logic cold_sel, input logic [3:0] set);
    @(negedge clk_in);
    cold_enab = set;
    start_c   = cold_sel;
    start_p   = 1'b1;
    @(negedge clk_in);
    start_p = 1'b0;
    if (cold_sel) begin
      act_m  = 4'h0;
      un_m   = 4'h0;
      enab_m = set;
    end
    @(negedge clk_in);
    `LAE_CHK(alarm, act_m)
    check_status();
  endtask : start
  // Enable, disable, local ack and setup change pulses
  task automatic pulse(input logic [3:0] set, input logic [3:0] clr,
                       input logic [3:0] ackm, input logic chg);
    @(negedge clk_in);
    {enab_set, enab_clr, ack, cfg_ch} = {set, clr, ackm, chg};
    @(negedge clk_in);
    {enab_set, enab_clr, ack, cfg_ch} = 13'h0000;
    enab_m    = (enab_m | set) & ~clr;
    act_m     = act_m & enab_m;
    un_m      = un_m & enab_m & ~ackm;
    changed_m = changed_m | chg;
    @(negedge clk_in);
    `LAE_CHK(alarm, act_m)
    check_status();
  endtask : pulse
  // Remote write and its effect on the flags
  task automatic remote(input logic [15:0] d);
    st.write_word(d);
    exempt_m = d[`LAE_OS_BIT];
    if (!d[`LAE_CC_BIT]) changed_m = 1'b0;
    if (!d[`LAE_NA_BIT]) un_m = 4'h0;
    @(negedge clk_in);
    check_status();
  endtask : remote
  // Verdict and end of run
  task automatic results();
    if (err_total == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results
  // Hang guard, well beyond the expected run
  initial begin
    #100000;
    err_total++;
    results();
  end
  // Main sequence
  initial begin
    {rst_n, strobe, start_p, start_c, rng_v, cfg_ch} = 6'h00;
    {proc, deviation, rng_low, rng_high} = 64'h0;
    {limit, dband, dly_i, dly_o} = 192'h0;
    {ringback, cold_enab, enab_set, enab_clr, ack} = {4'h1, 16'h0};
    prio = '{3'h1, 3'h5, 3'h1, 3'h1};
    for (int i = 0; i < 4; i++) kind[i] = LAE_NONE;
    {act_m, un_m, enab_m, exempt_m, changed_m} = 14'h0000;
    {err_total, comparisons} = 64'h0;
    repeat (20) @(negedge clk_in);
    rst_n = 1'b1;
    check_status();
    start(1'b1, 4'hF);
    cfg(0, LAE_UPPER_THRESHOLD, 50, 5);
    cfg(1, LAE_UNDER_THRESHOLD, 20, 5);
    cfg(2, LAE_POSITIVE_GAP, 10, 2);
    cfg(3, LAE_NEGATIVE_GAP, 10, 2);
    scan(30, 30, 4'b0000);
    scan(50, 30, 4'b0101);
    scan(46, 40, 4'b0001);
    scan(45, 40, 4'b0001);
    remote(16'h0000);
    scan(44, 40, 4'b0000);
    scan(20, 30, 4'b1010);
    scan(25, 30, 4'b0010);
    start(1'b0, 4'h0);
    scan(26, 30, 4'b0000);
    pulse(4'h0, 4'h0, 4'hF, 1'b0);
    pulse(4'h0, 4'h0, 4'h0, 1'b1);
    remote(16'hFFFF);
    remote(16'h5000);
    cfg(0, LAE_NONE, 0, 0);
    cfg(1, LAE_NONE, 0, 0);
    cfg(2, LAE_SETPOINT_GAP, 10, 2);
    cfg(3, LAE_SPAN_EXIT, 0, 5);
    scan(50, 50, 4'b0000);
    scan(40, 50, 4'b0100);
    scan(100, 95, 4'b1000);
    scan(96, 96, 4'b1000);
    scan(94, 94, 4'b0000);
    scan(0, 0, 4'b1000);
    scan(5, 5, 4'b1000);
    scan(6, 6, 4'b0000);
    rng_v    = 1'b1;
    rng_low  = -16'sd50;
    rng_high = 16'sd50;
    scan(50, 50, 4'b1000);
    scan(-10, -10, 4'b0000);
    scan(-50, -50, 4'b1000);
    pulse(4'b1000, 4'b1000, 4'h0, 1'b0);
    scan(-50, -50, 4'b0000);
    pulse(4'b1000, 4'h0, 4'h0, 1'b0);
    scan(-50, -50, 4'b1000);
    start(1'b1, 4'b0111);
    scan(-50, -50, 4'b0000);
    cfg(0, LAE_UPPER_THRESHOLD, 50, 5);
    cfg(2, LAE_NONE, 0, 0);
    dly_i[0] = 8'h02;
    dly_o[0] = 8'h01;
    scan(60, 0, 4'b0000);
    scan(60, 0, 4'b0000);
    scan(0, 0, 4'b0000);
    scan(60, 0, 4'b0000);
    scan(60, 0, 4'b0000);
    scan(60, 0, 4'b0001);
    scan(0, 0, 4'b0001);
    scan(0, 0, 4'b0000);
    results();
  end
endmodule : lae_loop_alarm_evaluator_tb_top
